// >>> hw/sms_status.v
`timescale 1ns/1ps
`include "sms_defs.vh"

//
// Contract
// - In position when deviation magnitude within range
// - Condition 0: deviation only, ignore command
// - Condition 1: no command and deviation small
// - Condition 2: also requires zero-speed output on
// - Condition 3: output latched after delay, held until next command
// - Condition 4: detect only after post-stop delay
// - Delay in milliseconds; zero means no delay
// - Coincidence when command minus feedback within range
// - Zero speed uses speed magnitude, both directions
module sms_status #(
  parameter MS_CYCLES = `SMS_DELAY_UNIT_NS / `SMS_CLK_PERIOD_NS
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        par_wr_en,
  input  wire        par_rd_en,
  input  wire [15:0] par_index,
  input  wire [15:0] par_wdata,
  output reg  [15:0] par_rdata,
  output reg         par_rd_valid,
  input  wire        pos_mode,
  input  wire        pos_cmd_active,
  input  wire [31:0] pos_deviation,
  input  wire [15:0] speed_fb,
  input  wire [15:0] speed_cmd,
  output reg         in_position_output,
  output reg         zero_speed_output,
  output reg         speed_reached_output,
  output reg         speed_coincidence_output
);

  // ----------------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------------
  reg  [15:0] positioning_complete_range_q;
  reg  [15:0] positioning_output_condition_q;
  reg  [15:0] positioning_delay_time_q;
  reg  [15:0] zero_speed_threshold_q;
  reg  [15:0] speed_coincidence_range_q;
  reg  [15:0] speed_reached_threshold_q;

  // New values land here and are seen by the comparators one cycle later
  always @(posedge clk) begin
    if (sys_rst) begin
      positioning_complete_range_q   <= `SMS_RST_POS_RANGE;
      positioning_output_condition_q <= `SMS_RST_OUT_COND;
      positioning_delay_time_q       <= `SMS_RST_DELAY_TIME;
      zero_speed_threshold_q         <= `SMS_RST_ZERO_THR;
      speed_coincidence_range_q      <= `SMS_RST_COIN_RANGE;
      speed_reached_threshold_q      <= `SMS_RST_REACH_THR;
    end else if (par_wr_en) begin
      case (par_index)
        `SMS_IDX_POS_RANGE:  positioning_complete_range_q   <= par_wdata;
        `SMS_IDX_OUT_COND:   positioning_output_condition_q <= par_wdata;
        `SMS_IDX_DELAY_TIME: positioning_delay_time_q       <= par_wdata;
        `SMS_IDX_ZERO_THR:   zero_speed_threshold_q         <= par_wdata;
        `SMS_IDX_COIN_RANGE: speed_coincidence_range_q      <= par_wdata;
        `SMS_IDX_REACH_THR:  speed_reached_threshold_q      <= par_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Magnitudes
  // ----------------------------------------------------------------------
  wire [31:0] dev_abs = pos_deviation[31] ? (~pos_deviation + 32'h00000001) : pos_deviation;
  wire        dev_near = (dev_abs <= {16'h0000, positioning_complete_range_q});

  // Full-scale negative maps to 0x8000, which still fits unsigned
  wire [15:0] spd_abs = speed_fb[15] ? (~speed_fb + 16'h0001) : speed_fb;

  wire [16:0] spd_err = {speed_cmd[15], speed_cmd} - {speed_fb[15], speed_fb};
  wire [16:0] err_abs = spd_err[16] ? (~spd_err + 17'h00001) : spd_err;
  wire        coin_c  = (err_abs <= {1'b0, speed_coincidence_range_q});

  // ----------------------------------------------------------------------
  // Speed detectors
  // ----------------------------------------------------------------------
  wire zero_det;
  wire reach_det;

  sms_hys #(
    .ABOVE (0)
  ) u_zero_hys (
    .clk     (clk),
    .sys_rst (sys_rst),
    .mag     (spd_abs),
    .thr     (zero_speed_threshold_q),
    .det_q   (zero_det)
  );

  sms_hys #(
    .ABOVE (1)
  ) u_reach_hys (
    .clk     (clk),
    .sys_rst (sys_rst),
    .mag     (spd_abs),
    .thr     (speed_reached_threshold_q),
    .det_q   (reach_det)
  );

  // ----------------------------------------------------------------------
  // Post-stop delay timer
  // ----------------------------------------------------------------------
  wire dly_done;

  sms_dly #(
    .MS_CYCLES (MS_CYCLES)
  ) u_dly (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .restart   (pos_cmd_active),
    .limit     (positioning_delay_time_q),
    .expired_q (dly_done)
  );

  // ----------------------------------------------------------------------
  // Hold latch for the timed condition
  // ----------------------------------------------------------------------
  // A zero delay expires on the first cycle after the stop, so the latch
  // then simply stays on until the next command arrives.
  reg hold_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      hold_q <= 1'b0;
    end else if (pos_cmd_active) begin
      hold_q <= 1'b0;
    end else if (dev_near && dly_done) begin
      hold_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // In-position qualification
  // ----------------------------------------------------------------------
  reg inp_c;

  always @* begin
    inp_c = 1'b0;
    case (positioning_output_condition_q)
      `SMS_COND_DEV_ONLY:   inp_c = dev_near;
      `SMS_COND_NO_CMD:     inp_c = dev_near && !pos_cmd_active;
      `SMS_COND_NO_CMD_ZS:  inp_c = dev_near && !pos_cmd_active && zero_det;
      `SMS_COND_HOLD_TIME:  inp_c = hold_q && !pos_cmd_active;
      `SMS_COND_LATE_START: inp_c = dev_near && !pos_cmd_active && dly_done;
      // Out-of-range codes fall back to the reset behaviour
      default:              inp_c = dev_near && !pos_cmd_active;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      in_position_output       <= 1'b0;
      zero_speed_output        <= 1'b0;
      speed_reached_output     <= 1'b0;
      speed_coincidence_output <= 1'b0;
    end else begin
      in_position_output       <= pos_mode && inp_c;
      zero_speed_output        <= zero_det;
      speed_reached_output     <= reach_det;
      speed_coincidence_output <= coin_c;
    end
  end

  // ----------------------------------------------------------------------
  // Parameter read-back
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      par_rdata    <= 16'h0000;
      par_rd_valid <= 1'b0;
    end else begin
      par_rd_valid <= par_rd_en;
      if (par_rd_en) begin
        case (par_index)
          `SMS_IDX_POS_RANGE:  par_rdata <= positioning_complete_range_q;
          `SMS_IDX_OUT_COND:   par_rdata <= positioning_output_condition_q;
          `SMS_IDX_DELAY_TIME: par_rdata <= positioning_delay_time_q;
          `SMS_IDX_ZERO_THR:   par_rdata <= zero_speed_threshold_q;
          `SMS_IDX_COIN_RANGE: par_rdata <= speed_coincidence_range_q;
          `SMS_IDX_REACH_THR:  par_rdata <= speed_reached_threshold_q;
          `SMS_IDX_STATUS: begin
            par_rdata <= 16'h0000;
            par_rdata[`SMS_ST_INP]      <= in_position_output;
            par_rdata[`SMS_ST_ZERO]     <= zero_speed_output;
            par_rdata[`SMS_ST_REACH]    <= speed_reached_output;
            par_rdata[`SMS_ST_COIN]     <= speed_coincidence_output;
            par_rdata[`SMS_ST_DLY_DONE] <= dly_done;
          end
          // Unknown index answers zero
          default:             par_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule // sms_status

// >>> shared/sms_defs.vh
`ifndef SMS_DEFS_VH
`define SMS_DEFS_VH

// ----------------------------------------------------------------------
// Parameter indices
// ----------------------------------------------------------------------
`define SMS_IDX_POS_RANGE    16'h2431
`define SMS_IDX_OUT_COND     16'h2432
`define SMS_IDX_DELAY_TIME   16'h2433
`define SMS_IDX_ZERO_THR     16'h2434
`define SMS_IDX_COIN_RANGE   16'h2435
`define SMS_IDX_REACH_THR    16'h2436
`define SMS_IDX_STATUS       16'h2440

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SMS_RST_POS_RANGE    16'h0014
`define SMS_RST_OUT_COND     16'h0001
`define SMS_RST_DELAY_TIME   16'h0000
`define SMS_RST_ZERO_THR     16'h0032
`define SMS_RST_COIN_RANGE   16'h0032
`define SMS_RST_REACH_THR    16'h03E8

// ----------------------------------------------------------------------
// Output condition codes
// ----------------------------------------------------------------------
`define SMS_COND_DEV_ONLY    16'h0000
`define SMS_COND_NO_CMD      16'h0001
`define SMS_COND_NO_CMD_ZS   16'h0002
`define SMS_COND_HOLD_TIME   16'h0003
`define SMS_COND_LATE_START  16'h0004

// ----------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------
`define SMS_ST_INP           0
`define SMS_ST_ZERO          1
`define SMS_ST_REACH         2
`define SMS_ST_COIN          3
`define SMS_ST_DLY_DONE      4

// ----------------------------------------------------------------------
// Timing and hysteresis
// ----------------------------------------------------------------------
`define SMS_HYST_RPM         17'h0000A
`define SMS_CLK_PERIOD_NS    50
`define SMS_DELAY_UNIT_NS    1000000

`endif

// >>> hw/sms_hys.v
`timescale 1ns/1ps
`include "sms_defs.vh"

module sms_hys #(
  parameter ABOVE = 1
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [15:0] mag,
  input  wire [15:0] thr,
  output reg         det_q
);

  // Both edges formed without subtraction so a threshold below the band cannot wrap
  wire over_hi  = {1'b0, mag} > ({1'b0, thr} + `SMS_HYST_RPM);
  wire under_lo = ({1'b0, mag} + `SMS_HYST_RPM) < {1'b0, thr};
  wire set_c    = (ABOVE != 0) ? over_hi : under_lo;
  wire clr_c    = (ABOVE != 0) ? under_lo : over_hi;

  always @(posedge clk) begin
    if (sys_rst) begin
      det_q <= 1'b0;
    end else if (set_c) begin
      det_q <= 1'b1;
    end else if (clr_c) begin
      det_q <= 1'b0;
    end
  end

endmodule // sms_hys

// >>> hw/sms_dly.v
`timescale 1ns/1ps
`include "sms_defs.vh"

module sms_dly #(
  parameter MS_CYCLES = 20000
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        restart,
  input  wire [15:0] limit,
  output reg         expired_q
);

  localparam PW = (MS_CYCLES > 2) ? $clog2(MS_CYCLES) : 1;
  localparam integer  PRE_LAST_I = MS_CYCLES - 1;
  localparam [PW-1:0] PRE_LAST   = PRE_LAST_I[PW-1:0];

  reg [PW-1:0] pre_q;
  reg [15:0]   ms_q;

  // Elapsed time saturates at the limit so a long idle never wraps
  always @(posedge clk) begin
    if (sys_rst || restart) begin
      pre_q     <= {PW{1'b0}};
      ms_q      <= 16'h0000;
      expired_q <= 1'b0;
    end else begin
      expired_q <= (ms_q >= limit);
      if (ms_q < limit) begin
        if (pre_q == PRE_LAST) begin
          pre_q <= {PW{1'b0}};
          ms_q  <= ms_q + 16'h0001;
        end else begin
          pre_q <= pre_q + {{(PW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // sms_dly

// >>> bench/sms_status_monitor.sv
`timescale 1ns/1ps
module sms_monitor #(
  parameter MS_CYCLES = 20000
) (
  input wire        clk,
  input wire        sys_rst,
  input wire        par_wr_en,
  input wire        par_rd_en,
  input wire [15:0] par_index,
  input wire [15:0] par_wdata,
  input wire [15:0] par_rdata,
  input wire        par_rd_valid,
  input wire        pos_mode,
  input wire        pos_cmd_active,
  input wire [31:0] pos_deviation,
  input wire [15:0] speed_fb,
  input wire [15:0] speed_cmd,
  input wire        in_position_output,
  input wire        zero_speed_output,
  input wire        speed_reached_output,
  input wire        speed_coincidence_output
);
  // ----
  // Shadow table keyed by low index nibble
  // ----
  logic [15:0] sh_q [0:15];
  always @(posedge clk) begin
    if (sys_rst) begin
      sh_q[1] <= 16'h0014;
      sh_q[2] <= 16'h0001;
      sh_q[4] <= 16'h0032;
      sh_q[5] <= 16'h0032;
      sh_q[6] <= 16'h03E8;
    end else if (par_wr_en && par_index[15:4] == 12'h243) begin
      sh_q[par_index[3:0]] <= par_wdata;
    end
  end
  wire signed [32:0] dev     = $signed(pos_deviation);
  wire        [32:0] dev_mag = dev < 0 ? -dev : dev;
  wire               near    = dev_mag <= {17'h0, sh_q[1]};
  wire               inp_exp = near && (sh_q[2] == 16'h0000 || !pos_cmd_active);
  wire signed [17:0] fb      = $signed(speed_fb);
  wire signed [17:0] fb_mag  = fb < 0 ? -fb : fb;
  wire signed [17:0] dif     = $signed(speed_cmd) - fb;
  wire signed [17:0] dif_mag = dif < 0 ? -dif : dif;
  wire               coin    = dif_mag <= $signed({2'b00, sh_q[5]});
  wire signed [17:0] zthr    = $signed({2'b00, sh_q[4]});
  wire signed [17:0] rthr    = $signed({2'b00, sh_q[6]});
  wire               rd_hit  = par_index >= 16'h2431 && par_index <= 16'h2436 && par_index != 16'h2433;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rd_data; par_rd_en && rd_hit |=> par_rdata == $past(sh_q[par_index[3:0]]); endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");
  property p_mode_off; !pos_mode |=> !in_position_output; endproperty
  a_mode_off: assert property (p_mode_off) else $error("in position outside position mode");
  property p_inp_basic; pos_mode && sh_q[2] <= 16'h0001 |=> in_position_output == $past(inp_exp); endproperty
  a_inp_basic: assert property (p_inp_basic) else $error("in position wrong");
  property p_inp_zs; !zero_speed_output && sh_q[2] == 16'h0002 ##1 !zero_speed_output |-> !in_position_output; endproperty
  a_inp_zs: assert property (p_inp_zs) else $error("in position without zero speed");
  property p_zs_on; fb_mag < zthr - 10 |-> ##2 zero_speed_output; endproperty
  a_zs_on: assert property (p_zs_on) else $error("zero speed not set");
  property p_zs_off; fb_mag > zthr + 10 |-> ##2 !zero_speed_output; endproperty
  a_zs_off: assert property (p_zs_off) else $error("zero speed not cleared");
  property p_rch_on; fb_mag > rthr + 10 |-> ##2 speed_reached_output; endproperty
  a_rch_on: assert property (p_rch_on) else $error("speed reached not set");
  property p_rch_off; fb_mag < rthr - 10 |-> ##2 !speed_reached_output; endproperty
  a_rch_off: assert property (p_rch_off) else $error("speed reached not cleared");
  property p_coin; 1'b1 |=> speed_coincidence_output == $past(coin); endproperty
  a_coin: assert property (p_coin) else $error("coincidence wrong");
endmodule // sms_monitor

bind sms_status sms_monitor #(.MS_CYCLES(MS_CYCLES)) i_mon (
  .clk(clk), .sys_rst(sys_rst), .par_wr_en(par_wr_en), .par_rd_en(par_rd_en),
  .par_index(par_index), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rd_valid(par_rd_valid),
  .pos_mode(pos_mode), .pos_cmd_active(pos_cmd_active), .pos_deviation(pos_deviation),
  .speed_fb(speed_fb), .speed_cmd(speed_cmd), .in_position_output(in_position_output),
  .zero_speed_output(zero_speed_output), .speed_reached_output(speed_reached_output),
  .speed_coincidence_output(speed_coincidence_output));

// >>> bench/sms_loop_model.sv
`timescale 1ns/1ps
// ----
// Control loop stand-in; bench targets pass straight to the loop outputs
// ----
module sms_loop_model (
  input  wire        mode_set,
  input  wire        busy_set,
  input  wire [31:0] dev_set,
  input  wire [15:0] fb_set,
  input  wire [15:0] cmd_set,
  output wire        pos_mode,
  output wire        pos_cmd_active,
  output wire [31:0] pos_deviation,
  output wire [15:0] speed_fb,
  output wire [15:0] speed_cmd
);
  assign pos_mode       = mode_set;
  assign pos_cmd_active = busy_set;
  assign pos_deviation  = dev_set;
  assign speed_fb       = fb_set;
  assign speed_cmd      = cmd_set;
endmodule // sms_loop_model

// >>> bench/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checked = checked + 1; \
    if ((g) !== (e)) begin \
      err_total = err_total + 1; \
      $display("BAD %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb;
  reg         clk, sys_rst, par_wr_en, par_rd_en, mode_set, busy_set;
  reg  [15:0] par_index, par_wdata, fb_set, cmd_set;
  reg  [31:0] dev_set;
  wire [15:0] par_rdata, speed_fb, speed_cmd;
  wire [31:0] pos_deviation;
  wire        par_rd_valid, pos_mode, pos_cmd_active, inp, zso, rch, coin;
  integer     err_total, checked;
  sms_loop_model i_loop (.mode_set(mode_set), .busy_set(busy_set), .dev_set(dev_set), .fb_set(fb_set),
    .cmd_set(cmd_set), .pos_mode(pos_mode), .pos_cmd_active(pos_cmd_active), .pos_deviation(pos_deviation),
    .speed_fb(speed_fb), .speed_cmd(speed_cmd));
  sms_status #(.MS_CYCLES(4)) i_dut (.clk(clk), .sys_rst(sys_rst), .par_wr_en(par_wr_en), .par_rd_en(par_rd_en),
    .par_index(par_index), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rd_valid(par_rd_valid),
    .pos_mode(pos_mode), .pos_cmd_active(pos_cmd_active), .pos_deviation(pos_deviation), .speed_fb(speed_fb),
    .speed_cmd(speed_cmd), .in_position_output(inp), .zero_speed_output(zso), .speed_reached_output(rch),
    .speed_coincidence_output(coin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task step(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input [15:0] i, input [15:0] d);
    begin
      par_index = i;
      par_wdata = d;
      par_wr_en = 1'b1;
      step(1);
      par_wr_en = 1'b0;
      step(1);
    end
  endtask
  task rd(input [15:0] i, input [15:0] e);
    begin
      par_index = i;
      par_rd_en = 1'b1;
      step(1);
      par_rd_en = 1'b0;
      `CHK("rd_valid", 1'b1, par_rd_valid)
      `CHK("rdata", e, par_rdata)
      step(1);
      `CHK("rd_valid_end", 1'b0, par_rd_valid)
    end
  endtask
  task put(input m, input b, input [31:0] d, input [15:0] f, input [15:0] c);
    begin
      mode_set = m;
      busy_set = b;
      dev_set = d;
      fb_set = f;
      cmd_set = c;
    end
  endtask
  task chk_inp(input m, input b, input [31:0] d, input [15:0] f, input e);
    begin
      put(m, b, d, f, 16'h0000);
      step(4);
      `CHK("in_position", e, inp)
    end
  endtask
  task chk_spd(input [15:0] f, input [15:0] c, input ez, input er, input ec);
    begin
      put(1'b1, 1'b0, 0, f, c);
      step(4);
      `CHK("zero_speed", ez, zso)
      `CHK("reached", er, rch)
      `CHK("coincide", ec, coin)
    end
  endtask
  task t_regs;
    begin
      rd(16'h2431, 16'h0014);
      rd(16'h2432, 16'h0001);
      rd(16'h2433, 16'h0000);
      rd(16'h2434, 16'h0032);
      rd(16'h2436, 16'h03E8);
      rd(16'h2435, 16'h0032);
      rd(16'h2437, 16'h0000);
      wr(16'h2431, 16'h2710);
      rd(16'h2431, 16'h2710);
      wr(16'h2431, 16'h0014);
      rd(16'h2440, 16'h001B);
      $display("test regs done");
    end
  endtask
  task t_inp;
    begin
      chk_inp(1, 0, 20, 0, 1);
      chk_inp(1, 0, -20, 0, 1);
      chk_inp(1, 0, 21, 0, 0);
      chk_inp(1, 1, 0, 0, 0);
      wr(16'h2432, 16'h0000);
      chk_inp(1, 1, 0, 0, 1);
      chk_inp(0, 1, 0, 0, 0);
      wr(16'h2432, 16'h0002);
      chk_inp(1, 0, 0, 100, 0);
      chk_inp(1, 0, 0, 0, 1);
      chk_inp(1, 1, 0, 0, 0);
      $display("test inp done");
    end
  endtask
  task t_delay(input [15:0] c);
    begin
      wr(16'h2432, c);
      wr(16'h2433, 16'h0002);
      chk_inp(1, 1, 0, 0, 0);
      chk_inp(1, 0, 0, 0, 0);
      step(10);
      `CHK("in_position", 1'b1, inp)
      $display("test delay done");
    end
  endtask
  task t_hold;
    begin
      chk_inp(1, 0, 500, 0, 1);
      chk_inp(1, 1, 500, 0, 0);
      wr(16'h2433, 16'h0000);
      chk_inp(1, 0, 0, 0, 1);
      chk_inp(1, 1, 0, 0, 0);
      $display("test hold done");
    end
  endtask
  task t_speed;
    begin
      chk_spd(39, 39, 1, 0, 1);
      chk_spd(55, 0, 1, 0, 0);
      chk_spd(61, 500, 0, 0, 0);
      chk_spd(-39, 0, 1, 0, 1);
      chk_spd(-61, 0, 0, 0, 0);
      chk_spd(1011, 1011, 0, 1, 1);
      chk_spd(995, 1045, 0, 1, 1);
      chk_spd(989, 1040, 0, 0, 0);
      wr(16'h2434, 16'h07D0);
      chk_spd(1500, 1500, 1, 1, 1);
      wr(16'h2435, 16'h0064);
      chk_spd(1500, 1560, 1, 1, 1);
      $display("test speed done");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    err_total = 0;
    checked = 0;
    sys_rst = 1'b1;
    par_wr_en = 1'b0;
    par_rd_en = 1'b0;
    par_index = 16'h0000;
    par_wdata = 16'h0000;
    put(1'b1, 1'b0, 0, 16'h0000, 16'h0000);
    step(2);
    sys_rst = 1'b0;
    t_regs;
    t_inp;
    t_delay(16'h0004);
    t_delay(16'h0003);
    t_hold;
    t_speed;
    print_verdict;
  end
endmodule // tb
